/* File: verilog/bscan_pkg.sv */
package bscan_pkg;

    // Register lengths
    localparam int IR_LEN = 3;
    localparam int BSR_LEN_SMALL = 522;
    localparam int BSR_LEN_MID = 621;
    localparam int BSR_LEN_LARGE = 666;
    localparam int CELLS_PER_PIN = 3;

    // Cell order within one pin's group
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    // Instruction codes and capture pattern
    localparam logic [IR_LEN-1:0] OP_EXTEST = 3'h0;
    localparam logic [IR_LEN-1:0] OP_SAMPLE = 3'h5;
    localparam logic [IR_LEN-1:0] OP_BYPASS = 3'h7;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;

    // Test access port controller states
    typedef enum logic [3:0] {
        TEST_RESET,
        RUN_IDLE,
        SEL_DR,
        CAP_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPD_DR,
        SEL_IR,
        CAP_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPD_IR
    } tap_state_t;

endpackage : bscan_pkg

/* File: verilog/sync2.sv */
`timescale 1ns/1ps

module sync2 #(
    parameter int W = 1
) (
    // Destination domain
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : sync2

/* File: verilog/boundary_scan_tap.sv */
`timescale 1ns/1ps

module boundary_scan_tap #(
    parameter int BSR_LEN = bscan_pkg::BSR_LEN_SMALL
) (
    // System clock domain
    input wire logic clock,
    input wire logic srst,
    // Scan port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Configuration status
    input wire logic cfg_busy,
    input wire logic cfg_done,
    // Core and pads
    input wire logic [BSR_LEN/bscan_pkg::CELLS_PER_PIN-1:0] core_out,
    input wire logic [BSR_LEN/bscan_pkg::CELLS_PER_PIN-1:0] core_oe,
    input wire logic [BSR_LEN/bscan_pkg::CELLS_PER_PIN-1:0] pin_in,
    output logic [BSR_LEN/bscan_pkg::CELLS_PER_PIN-1:0] pin_out,
    output logic [BSR_LEN/bscan_pkg::CELLS_PER_PIN-1:0] pin_oe
);

    localparam int NPIN = BSR_LEN / bscan_pkg::CELLS_PER_PIN;

    function automatic logic uses_bsr(input logic [bscan_pkg::IR_LEN-1:0] op,
                                      input logic busy);
        uses_bsr = !busy && (op == bscan_pkg::OP_EXTEST || op == bscan_pkg::OP_SAMPLE);
    endfunction : uses_bsr

    ////////////////////////////////////////////////////////////////////////////////////
    // Crossings into the scan clock

    logic tap_rst;
    logic cfg_busy_t;
    logic [NPIN-1:0] pin_t;
    logic [2*NPIN-1:0] core_t;

    sync2 #(.W(1)) u_rst_sync (.clk(tck), .rst(1'b0), .d(srst), .q(tap_rst));
    sync2 #(.W(1)) u_busy_sync (.clk(tck), .rst(tap_rst), .d(cfg_busy), .q(cfg_busy_t));
    sync2 #(.W(NPIN)) u_pin_sync (.clk(tck), .rst(tap_rst), .d(pin_in), .q(pin_t));
    sync2 #(.W(2*NPIN)) u_core_sync (
        .clk(tck),
        .rst(tap_rst),
        .d({core_oe, core_out}),
        .q(core_t)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // Controller

    bscan_pkg::tap_state_t state_r;
    bscan_pkg::tap_state_t state_nxt;

    always_comb
    begin
        case (state_r)
            bscan_pkg::TEST_RESET: state_nxt = tms ? bscan_pkg::TEST_RESET : bscan_pkg::RUN_IDLE;
            bscan_pkg::RUN_IDLE: state_nxt = tms ? bscan_pkg::SEL_DR : bscan_pkg::RUN_IDLE;
            bscan_pkg::SEL_DR: state_nxt = tms ? bscan_pkg::SEL_IR : bscan_pkg::CAP_DR;
            bscan_pkg::CAP_DR: state_nxt = tms ? bscan_pkg::EXIT1_DR : bscan_pkg::SHIFT_DR;
            bscan_pkg::SHIFT_DR: state_nxt = tms ? bscan_pkg::EXIT1_DR : bscan_pkg::SHIFT_DR;
            bscan_pkg::EXIT1_DR: state_nxt = tms ? bscan_pkg::UPD_DR : bscan_pkg::PAUSE_DR;
            bscan_pkg::PAUSE_DR: state_nxt = tms ? bscan_pkg::EXIT2_DR : bscan_pkg::PAUSE_DR;
            bscan_pkg::EXIT2_DR: state_nxt = tms ? bscan_pkg::UPD_DR : bscan_pkg::SHIFT_DR;
            bscan_pkg::UPD_DR: state_nxt = tms ? bscan_pkg::SEL_DR : bscan_pkg::RUN_IDLE;
            bscan_pkg::SEL_IR: state_nxt = tms ? bscan_pkg::TEST_RESET : bscan_pkg::CAP_IR;
            bscan_pkg::CAP_IR: state_nxt = tms ? bscan_pkg::EXIT1_IR : bscan_pkg::SHIFT_IR;
            bscan_pkg::SHIFT_IR: state_nxt = tms ? bscan_pkg::EXIT1_IR : bscan_pkg::SHIFT_IR;
            bscan_pkg::EXIT1_IR: state_nxt = tms ? bscan_pkg::UPD_IR : bscan_pkg::PAUSE_IR;
            bscan_pkg::PAUSE_IR: state_nxt = tms ? bscan_pkg::EXIT2_IR : bscan_pkg::PAUSE_IR;
            bscan_pkg::EXIT2_IR: state_nxt = tms ? bscan_pkg::UPD_IR : bscan_pkg::SHIFT_IR;
            bscan_pkg::UPD_IR: state_nxt = tms ? bscan_pkg::SEL_DR : bscan_pkg::RUN_IDLE;
            default: state_nxt = bscan_pkg::TEST_RESET;
        endcase
    end

    // Floating TMS reads high and walks the controller into reset
    always_ff @(posedge tck)
    begin
        if (tap_rst)
            state_r <= bscan_pkg::TEST_RESET;
        else
            state_r <= state_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Instruction register

    logic [bscan_pkg::IR_LEN-1:0] ir_shift_r;
    logic [bscan_pkg::IR_LEN-1:0] ir_r;
    logic bsr_sel;
    logic extest_t;

    always_ff @(posedge tck)
    begin
        if (tap_rst)
            ir_shift_r <= bscan_pkg::IR_CAPTURE;
        else if (state_r == bscan_pkg::CAP_IR)
            ir_shift_r <= bscan_pkg::IR_CAPTURE;
        else if (state_r == bscan_pkg::SHIFT_IR)
            ir_shift_r <= {tdi, ir_shift_r[bscan_pkg::IR_LEN-1:1]};
    end

    always_ff @(posedge tck)
    begin
        if (tap_rst || state_r == bscan_pkg::TEST_RESET)
            ir_r <= bscan_pkg::OP_BYPASS;
        else if (state_r == bscan_pkg::UPD_IR)
            ir_r <= ir_shift_r;
    end

    // Unknown codes and configuration in progress fall back to bypass
    assign bsr_sel = uses_bsr(ir_r, cfg_busy_t);
    assign extest_t = uses_bsr(ir_r, cfg_busy_t) && ir_r == bscan_pkg::OP_EXTEST;

    ////////////////////////////////////////////////////////////////////////////////////
    // Data registers

    logic bypass_r;
    logic [BSR_LEN-1:0] cap_vec;
    logic [BSR_LEN-1:0] bsr_r;
    logic [BSR_LEN-1:0] upd_r;
    logic upd_tog_r;

    for (genvar i = 0; i < NPIN; i++)
    begin : g_cap
        assign cap_vec[bscan_pkg::CELLS_PER_PIN*i+bscan_pkg::CELL_IN] = pin_t[i];
        assign cap_vec[bscan_pkg::CELLS_PER_PIN*i+bscan_pkg::CELL_OUT] = core_t[i];
        assign cap_vec[bscan_pkg::CELLS_PER_PIN*i+bscan_pkg::CELL_OE] = core_t[NPIN+i];
    end

    always_ff @(posedge tck)
    begin
        if (tap_rst || state_r == bscan_pkg::CAP_DR)
            bypass_r <= 1'b0;
        else if (state_r == bscan_pkg::SHIFT_DR)
            bypass_r <= tdi;
    end

    always_ff @(posedge tck)
    begin
        if (tap_rst)
            bsr_r <= '0;
        else if (bsr_sel && state_r == bscan_pkg::CAP_DR)
            bsr_r <= cap_vec;
        else if (bsr_sel && state_r == bscan_pkg::SHIFT_DR)
            bsr_r <= {tdi, bsr_r[BSR_LEN-1:1]};
    end

    // Update cells keep the preload pattern while the core runs
    always_ff @(posedge tck)
    begin
        if (tap_rst)
        begin
            upd_r <= '0;
            upd_tog_r <= 1'b0;
        end
        else if (bsr_sel && state_r == bscan_pkg::UPD_DR)
        begin
            upd_r <= bsr_r;
            upd_tog_r <= !upd_tog_r;
        end
    end

    // Output changes on the falling edge of the scan clock
    always_ff @(negedge tck)
    begin
        if (tap_rst)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else
        begin
            tdo_oe <= state_r == bscan_pkg::SHIFT_IR || state_r == bscan_pkg::SHIFT_DR;
            if (state_r == bscan_pkg::SHIFT_IR)
                tdo <= ir_shift_r[0];
            else if (state_r == bscan_pkg::SHIFT_DR)
                tdo <= bsr_sel ? bsr_r[0] : bypass_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Crossings back and pad drivers

    logic extest_c;
    logic tog_c;
    logic tog_seen_r;
    logic [BSR_LEN-1:0] upd_c_r;

    sync2 #(.W(1)) u_ext_sync (.clk(clock), .rst(srst), .d(extest_t), .q(extest_c));
    sync2 #(.W(1)) u_tog_sync (.clk(clock), .rst(srst), .d(upd_tog_r), .q(tog_c));

    // Update cells are stable for many clocks after each toggle
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            tog_seen_r <= 1'b0;
            upd_c_r <= '0;
        end
        else
        begin
            tog_seen_r <= tog_c;
            if (tog_c != tog_seen_r)
                upd_c_r <= upd_r;
        end
    end

    for (genvar i = 0; i < NPIN; i++)
    begin : g_pad
        always_ff @(posedge clock)
        begin
            if (srst)
            begin
                pin_out[i] <= 1'b0;
                pin_oe[i] <= 1'b0;
            end
            else if (extest_c)
            begin
                pin_out[i] <= upd_c_r[bscan_pkg::CELLS_PER_PIN*i+bscan_pkg::CELL_OUT];
                pin_oe[i] <= upd_c_r[bscan_pkg::CELLS_PER_PIN*i+bscan_pkg::CELL_OE];
            end
            else
            begin
                pin_out[i] <= core_out[i];
                pin_oe[i] <= cfg_done && core_oe[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge tck);
    endclocking
    default disable iff (tap_rst);

    a_tms_reset_walk: assert property (tms [*5] |=> state_r == bscan_pkg::TEST_RESET)
        else $error("five TMS highs did not reach reset");
    a_ir_capture_pat: assert property (state_r == bscan_pkg::CAP_IR
        |=> ir_shift_r[1:0] == 2'h1)
        else $error("instruction capture pattern wrong");
    a_ir_update_load: assert property (state_r == bscan_pkg::UPD_IR
        |=> ir_r == $past(ir_shift_r))
        else $error("instruction not loaded on update");
    a_bypass_capture_zero: assert property (state_r == bscan_pkg::CAP_DR
        |=> bypass_r == 1'b0)
        else $error("bypass did not capture zero");
    a_busy_blocks_scan: assert property (cfg_busy_t |-> !bsr_sel && !extest_t)
        else $error("scan register selected during configuration");
    a_unknown_op_bypass: assert property (ir_r != bscan_pkg::OP_EXTEST
        && ir_r != bscan_pkg::OP_SAMPLE |-> !bsr_sel)
        else $error("unassigned code selected scan register");
    a_bsr_shift_in: assert property (bsr_sel && state_r == bscan_pkg::SHIFT_DR
        |=> bsr_r[BSR_LEN-1] == $past(tdi)
        && bsr_r[BSR_LEN-2:0] == $past(bsr_r[BSR_LEN-1:1]))
        else $error("scan register shift wrong");
    a_update_holds: assert property (bsr_sel && state_r == bscan_pkg::UPD_DR
        |=> upd_r == $past(bsr_r))
        else $error("update cells not loaded");
    a_extest_select: assert property (ir_r == bscan_pkg::OP_EXTEST && !cfg_busy_t
        |-> extest_t)
        else $error("external test not selected");
    a_powerup_quiet: assert property (@(posedge clock) disable iff (1'b0)
        srst |=> pin_oe == '0)
        else $error("pins driven during reset");

    c_extest_update: cover property (extest_t && state_r == bscan_pkg::UPD_DR);
    c_sample_capture: cover property (ir_r == bscan_pkg::OP_SAMPLE
        && state_r == bscan_pkg::CAP_DR);
    c_bypass_shift: cover property ((!bsr_sel && state_r == bscan_pkg::SHIFT_DR) [*3]);
    c_ir_update: cover property (state_r == bscan_pkg::UPD_IR);

endmodule : boundary_scan_tap

/* File: verification/jtag_ctrl.sv */
`timescale 1ns/1ps

module jtag_ctrl (
    // Scan port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    localparam int MAXLEN = bscan_pkg::BSR_LEN_LARGE;

    // Idle lines sit at the pulled-up level, clock stands low
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One 32 ns scan clock period; tdo taken at the rise
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #16;
        tck = 1'b1;
        o = tdo;
        #16;
        tck = 1'b0;
    endtask : tick

    task automatic reset_tap();
        logic o;
        repeat (5) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask : reset_tap

    task automatic scan_ir(input logic [2:0] code, output logic [2:0] cap);
        logic o;
        tick(1'b1, 1'b1, o);
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < 3; i++) tick(i == 2, code[i], cap[i]);
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask : scan_ir

    task automatic scan_dr(input int n, input logic [MAXLEN-1:0] din,
                           output logic [MAXLEN-1:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask : scan_dr
endmodule : jtag_ctrl

/* File: verification/tb.sv */
`timescale 1ns/1ps

module tb;
    localparam int LEN = bscan_pkg::BSR_LEN_SMALL;
    localparam int NPIN = LEN / bscan_pkg::CELLS_PER_PIN;
    localparam int MAXLEN = bscan_pkg::BSR_LEN_LARGE;
    localparam logic [LEN-1:0] PRE = {87{6'b10_0110}};

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cfg_busy = 1'b0;
    logic cfg_done = 1'b0;
    logic [NPIN-1:0] core_out = {58{3'b101}};
    logic [NPIN-1:0] core_oe = {58{3'b011}};
    logic [NPIN-1:0] pin_in = {58{3'b110}};
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pin_oe;
    logic [MAXLEN-1:0] dout;
    logic [2:0] cap;
    wire tck, tms, tdi, tdo, tdo_oe, tdo_line;
    int num_errors = 0;
    int num_checks = 0;

    always #2.5 clock = ~clock;
    // Released data out reads high
    assign tdo_line = tdo_oe ? tdo : 1'b1;

    boundary_scan_tap #(.BSR_LEN(LEN)) i_dut (.clock(clock), .srst(srst), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .cfg_busy(cfg_busy),
        .cfg_done(cfg_done), .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    jtag_ctrl i_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

    task automatic check(input logic [LEN-1:0] seen, input logic [LEN-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // Capture image: input, output data, output enable per pin
    function automatic logic [LEN-1:0] cap_exp();
        logic [LEN-1:0] e;
        for (int i = 0; i < NPIN; i++) e[3*i +: 3] = {core_oe[i], core_out[i], pin_in[i]};
        return e;
    endfunction : cap_exp

    task automatic t_codes();
        logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
        foreach (codes[k])
        begin
            i_ctrl.scan_ir(codes[k], cap);
            check(LEN'(cap), LEN'(bscan_pkg::IR_CAPTURE));
            i_ctrl.scan_dr(8, MAXLEN'(8'hA5), dout);
            check(LEN'(dout[7:0]), LEN'(8'h4A));
        end
        check(LEN'(pin_out), LEN'(core_out));
    endtask : t_codes

    task automatic t_sample();
        i_ctrl.scan_ir(bscan_pkg::OP_SAMPLE, cap);
        repeat (10) @(posedge clock);
        check(LEN'(pin_out), LEN'(core_out));
        check(LEN'(pin_oe), LEN'(core_oe));
        i_ctrl.scan_dr(LEN + 1, MAXLEN'({PRE, 1'b1}), dout);
        check(dout[LEN-1:0], cap_exp());
        check(LEN'(dout[LEN]), LEN'(1'b1));
    endtask : t_sample

    task automatic t_extest();
        logic [NPIN-1:0] eo, ee, ci;
        i_ctrl.scan_ir(bscan_pkg::OP_EXTEST, cap);
        repeat (12) @(posedge clock);
        for (int i = 0; i < NPIN; i++) {ee[i], eo[i]} = PRE[3*i+1 +: 2];
        check(LEN'(pin_out), LEN'(eo));
        check(LEN'(pin_oe), LEN'(ee));
        i_ctrl.scan_dr(LEN, MAXLEN'(PRE), dout);
        for (int i = 0; i < NPIN; i++) ci[i] = dout[3*i];
        check(LEN'(ci), LEN'(pin_in));
    endtask : t_extest

    task automatic t_config();
        @(posedge clock) cfg_busy <= 1'b1;
        repeat (5) @(posedge clock);
        i_ctrl.scan_ir(bscan_pkg::OP_SAMPLE, cap);
        i_ctrl.scan_dr(8, MAXLEN'(8'h3C), dout);
        check(LEN'(dout[7:0]), LEN'(8'h78));
        @(posedge clock) cfg_busy <= 1'b0;
        repeat (5) @(posedge clock);
        i_ctrl.scan_ir(bscan_pkg::OP_SAMPLE, cap);
        i_ctrl.scan_dr(8, MAXLEN'(8'h3C), dout);
        check(LEN'(dout[7:0]), LEN'(cap_exp() & LEN'(8'hFF)));
    endtask : t_config

    initial
    begin
        fork
            repeat (6) @(posedge clock);
            i_ctrl.reset_tap();
        join
        check(LEN'(pin_oe), '0);
        check(LEN'(tdo_oe), '0);
        @(posedge clock) srst <= 1'b0;
        i_ctrl.reset_tap();
        check(LEN'(pin_oe), '0);
        @(posedge clock) cfg_done <= 1'b1;
        t_codes();
        t_sample();
        t_extest();
        t_config();
        give_verdict();
    end

    // Watchdog
    initial
    begin
        #400_000;
        num_errors++;
        give_verdict();
    end
endmodule : tb
